/* hdl/embi_bus_top.sv */
// Purpose: external memory bus sequencer with selects and bus hand-off
// Assumes: internal requests come from the same clock domain
// Notes: every pin output is registered; the drive enables are registered from the next state
`include "embi_map.svh"
module embi_bus_top
  import embi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_dummy,
  input wire logic [`EMBI_ADDR_W-1:0] req_addr,
  input wire logic [`EMBI_DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_be,
  output logic req_ready,
  output logic rsp_valid,
  output logic [`EMBI_DATA_W-1:0] rsp_rdata,
  input wire logic [`EMBI_SEL_N-1:0][`EMBI_ADDR_W-1:0] sel_base,
  input wire logic [`EMBI_SEL_N-1:0][`EMBI_ADDR_W-1:0] sel_mask,
  input wire logic [`EMBI_SEL_N-1:0] sel_enable,
  input wire logic [`EMBI_SEL_N-1:0] sel_dram,
  input wire logic [`EMBI_SEL_N-1:0] sel_bus8,
  input wire logic upper_group_high,
  input wire logic ale_enable,
  input wire logic clk_out_enable,
  input wire logic pull_enable,
  input wire logic rom_less,
  input wire logic bus_width_strap,
  input wire logic wait_n,
  input wire logic external_master_request_n,
  output logic external_master_grant_n,
  input wire logic [`EMBI_DATA_W-1:0] muxed_addr_data_lines_in,
  output logic [`EMBI_DATA_W-1:0] muxed_addr_data_lines_out,
  output logic [`EMBI_DATA_W-1:0] muxed_addr_data_lines_oe,
  output logic [`EMBI_GRP_W-1:0] address_lines,
  output logic address_lines_oe,
  output logic ctl_oe,
  output logic read_strobe_n,
  output logic lower_byte_write_strobe_n,
  output logic upper_byte_write_strobe_n,
  output logic read_write,
  output logic row_strobe_n,
  output logic select_zero_n,
  output logic select_one_n,
  output logic select_two_n,
  output logic addr_latch,
  output logic addr_latch_oe,
  output logic clk_div_out,
  output logic clk_div_oe,
  output logic pull_connect,
  output logic port_bus_fixed
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Pin synchronisers
  logic [1:0] wait_sy;
  logic [1:0] mreq_sy;
  logic [1:0] strap_sy;
  logic [1:0] rl_sy;
  logic [`EMBI_DATA_W-1:0] ad_s1;
  logic [`EMBI_DATA_W-1:0] ad_s2;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_sy <= 2'h3;
      mreq_sy <= 2'h3;
      strap_sy <= 2'h0;
      rl_sy <= 2'h0;
      ad_s1 <= 16'h0000;
      ad_s2 <= 16'h0000;
    end else begin
      wait_sy <= {wait_sy[0], wait_n};
      mreq_sy <= {mreq_sy[0], external_master_request_n};
      strap_sy <= {strap_sy[0], bus_width_strap};
      rl_sy <= {rl_sy[0], rom_less};
      ad_s1 <= muxed_addr_data_lines_in;
      ad_s2 <= ad_s1;
    end
  end

  logic wait_req;
  logic master_req;
  logic strap_s;
  logic rom_less_s;
  assign wait_req = !wait_sy[1];
  assign master_req = !mreq_sy[1];
  assign strap_s = strap_sy[1];
  assign rom_less_s = rl_sy[1];

  // Sequencer state
  embi_state_t state_reg, state_next;
  logic [`EMBI_CNT_W-1:0] cnt_reg, cnt_next;
  logic [`EMBI_ADDR_W-1:0] addr_reg, addr_next;
  logic [`EMBI_DATA_W-1:0] wdata_reg, wdata_next;
  logic [`EMBI_DATA_W-1:0] rdata_reg, rdata_next;
  logic [1:0] be_reg, be_next;
  logic write_reg, write_next;
  logic dummy_reg, dummy_next;
  logic bus8_reg, bus8_next;
  logic beat_hi_reg, beat_hi_next;
  logic two_reg, two_next;
  logic rsp_reg, rsp_next;

  logic [`EMBI_SEL_N-1:0] sel_hit;
  logic [`EMBI_SEL_N-1:0] sel_pin_n;
  logic [`EMBI_ADDR_W-1:0] cyc_addr;
  logic [`EMBI_ADDR_W-1:0] dec_addr;
  logic width8_now;
  logic in_cycle;
  logic strb_ph;
  logic cas_ph;

  // 24-bit address reaches the full 16M byte space when upper_group_high puts A23..16 on the group
  assign cyc_addr = {addr_reg[23:1], addr_reg[0] | beat_hi_reg};
  assign dec_addr = (state_reg == EMBI_ST_IDLE) ? req_addr : cyc_addr;
  // ROM-less part takes width from the strap, else per select
  assign width8_now = rom_less_s ? strap_s : |(sel_hit & sel_bus8);
  assign in_cycle = (state_reg == EMBI_ST_ADDR) ||
                    (state_reg == EMBI_ST_STRB) ||
                    (state_reg == EMBI_ST_HOLD);
  assign strb_ph = (state_reg == EMBI_ST_STRB);
  assign cas_ph = strb_ph && (cnt_reg != `EMBI_STRB_CYC - `EMBI_CAS_DLY);

  // Held off during a grant, so the outside master never meets us
  assign req_ready = (state_reg == EMBI_ST_IDLE) && !master_req;

  genvar gi;
  generate
    for (gi = 0; gi < `EMBI_SEL_N; gi = gi + 1) begin : g_sel
      embi_sel_if sel_bus ();
      assign sel_bus.addr = dec_addr;
      assign sel_bus.base = sel_base[gi];
      assign sel_bus.mask = sel_mask[gi];
      assign sel_bus.enable = sel_enable[gi];
      assign sel_bus.dram = sel_dram[gi];
      assign sel_bus.drive = in_cycle;
      assign sel_bus.cas = cas_ph;
      assign sel_hit[gi] = sel_bus.hit;
      assign sel_pin_n[gi] = sel_bus.pin_n;
      embi_sel_decode u_dec (
        .clk(clk),
        .rst_n(rst_n),
        .sel(sel_bus)
      );
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    be_next = be_reg;
    write_next = write_reg;
    dummy_next = dummy_reg;
    bus8_next = bus8_reg;
    beat_hi_next = beat_hi_reg;
    two_next = two_reg;
    rsp_next = 1'b0;
    case (state_reg)
      EMBI_ST_IDLE: begin
        if (master_req) begin
          state_next = EMBI_ST_GRANT;
        end else if (req_valid) begin
          addr_next = req_addr;
          wdata_next = req_wdata;
          be_next = req_be;
          write_next = req_write && !req_dummy;
          dummy_next = req_dummy;
          bus8_next = width8_now;
          // Narrow bus splits a word into two byte beats
          beat_hi_next = width8_now && (req_be == 2'h2);
          two_next = width8_now && (req_be == 2'h3);
          state_next = EMBI_ST_ADDR;
        end
      end
      EMBI_ST_ADDR: begin
        cnt_next = `EMBI_STRB_CYC - 2'h1;
        state_next = EMBI_ST_STRB;
      end
      EMBI_ST_STRB: begin
        if (cnt_reg != 2'h0) begin
          cnt_next = cnt_reg - 2'h1;
        end else if (!wait_req) begin
          state_next = EMBI_ST_HOLD;
        end
      end
      EMBI_ST_HOLD: begin
        // Data path lags the pins by two flops, so sample one cycle late
        if (!write_reg) begin
          if (!bus8_reg) begin
            rdata_next = ad_s2;
          end else if (beat_hi_reg) begin
            rdata_next[15:8] = ad_s2[7:0];
          end else begin
            rdata_next[7:0] = ad_s2[7:0];
          end
        end
        if (two_reg && !beat_hi_reg) begin
          beat_hi_next = 1'b1;
          state_next = EMBI_ST_ADDR;
        end else begin
          rsp_next = 1'b1;
          state_next = EMBI_ST_IDLE;
        end
      end
      EMBI_ST_GRANT: begin
        if (!master_req) begin
          state_next = EMBI_ST_IDLE;
        end
      end
      default: begin
        state_next = EMBI_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= EMBI_ST_IDLE;
      cnt_reg <= 2'h0;
      addr_reg <= 24'h000000;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      be_reg <= 2'h0;
      write_reg <= 1'b0;
      dummy_reg <= 1'b0;
      bus8_reg <= 1'b0;
      beat_hi_reg <= 1'b0;
      two_reg <= 1'b0;
      rsp_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      be_reg <= be_next;
      write_reg <= write_next;
      dummy_reg <= dummy_next;
      bus8_reg <= bus8_next;
      beat_hi_reg <= beat_hi_next;
      two_reg <= two_next;
      rsp_reg <= rsp_next;
    end
  end

  assign rsp_valid = rsp_reg;
  assign rsp_rdata = rdata_reg;

  // Pin state
  logic [`EMBI_DATA_W-1:0] ad_out_reg, ad_out_next;
  logic [`EMBI_DATA_W-1:0] ad_oe_reg, ad_oe_next;
  logic [`EMBI_GRP_W-1:0] grp_reg, grp_next;
  logic drive_reg, drive_next;
  logic rd_n_reg, rd_n_next;
  logic wrl_n_reg, wrl_n_next;
  logic wrh_n_reg, wrh_n_next;
  logic rw_reg, rw_next;
  logic ras_n_reg, ras_n_next;
  logic ale_reg, ale_next;
  logic ale_oe_reg, ale_oe_next;
  logic grant_n_reg, grant_n_next;
  logic clkdiv_reg, clkdiv_next;
  logic clkdiv_oe_reg, clkdiv_oe_next;
  logic pull_reg, pull_next;
  logic fixed_reg, fixed_next;
  logic [7:0] low_lane;
  logic wr_data;

  always_comb begin
    low_lane = beat_hi_reg ? wdata_reg[15:8] : wdata_reg[7:0];
    wr_data = write_reg && (strb_ph || state_reg == EMBI_ST_HOLD);
    ad_out_next = ad_out_reg;
    ad_oe_next = 16'h0000;
    if (state_reg == EMBI_ST_ADDR) begin
      ad_out_next = cyc_addr[15:0];
      ad_oe_next = 16'hFFFF;
    end else if (in_cycle && bus8_reg) begin
      // Narrow bus keeps the upper lines as address only
      ad_out_next = {cyc_addr[15:8], low_lane};
      ad_oe_next = {`EMBI_LANE_ON, wr_data ? `EMBI_LANE_ON : `EMBI_LANE_OFF};
    end else if (wr_data) begin
      ad_out_next = wdata_reg;
      ad_oe_next = 16'hFFFF;
    end
    grp_next = upper_group_high ? cyc_addr[23:16] : cyc_addr[7:0];
    drive_next = (state_next != EMBI_ST_GRANT) &&
                 (state_reg != EMBI_ST_GRANT);
    rd_n_next = !(strb_ph && !write_reg && !dummy_reg);
    wrl_n_next = !(strb_ph && write_reg && (bus8_reg || be_reg[0]));
    wrh_n_next = !(strb_ph && write_reg && !bus8_reg && be_reg[1]);
    rw_next = !(in_cycle && write_reg);
    ras_n_next = !(|(sel_hit & sel_dram) &&
                   (strb_ph || state_reg == EMBI_ST_HOLD));
    ale_next = (state_reg == EMBI_ST_ADDR);
    ale_oe_next = ale_enable;
    grant_n_next = !(state_reg == EMBI_ST_GRANT) || !master_req;
    clkdiv_next = !clkdiv_reg;
    clkdiv_oe_next = clk_out_enable;
    pull_next = pull_enable;
    fixed_next = rom_less_s;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ad_out_reg <= 16'h0000;
      ad_oe_reg <= 16'h0000;
      grp_reg <= 8'h00;
      drive_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      wrl_n_reg <= 1'b1;
      wrh_n_reg <= 1'b1;
      rw_reg <= 1'b1;
      ras_n_reg <= 1'b1;
      ale_reg <= 1'b0;
      ale_oe_reg <= 1'b1;
      grant_n_reg <= 1'b1;
      clkdiv_reg <= `EMBI_CLKDIV_RST;
      clkdiv_oe_reg <= 1'b1;
      pull_reg <= 1'b1;
      fixed_reg <= 1'b0;
    end else begin
      ad_out_reg <= ad_out_next;
      ad_oe_reg <= drive_next ? ad_oe_next : 16'h0000;
      grp_reg <= grp_next;
      drive_reg <= drive_next;
      rd_n_reg <= rd_n_next;
      wrl_n_reg <= wrl_n_next;
      wrh_n_reg <= wrh_n_next;
      rw_reg <= rw_next;
      ras_n_reg <= ras_n_next;
      ale_reg <= ale_next;
      ale_oe_reg <= ale_oe_next;
      grant_n_reg <= grant_n_next;
      clkdiv_reg <= clkdiv_next;
      clkdiv_oe_reg <= clkdiv_oe_next;
      pull_reg <= pull_next;
      fixed_reg <= fixed_next;
    end
  end

  assign muxed_addr_data_lines_out = ad_out_reg;
  assign muxed_addr_data_lines_oe = ad_oe_reg;
  assign address_lines = grp_reg;
  assign address_lines_oe = drive_reg;
  assign ctl_oe = drive_reg;
  assign read_strobe_n = rd_n_reg;
  assign lower_byte_write_strobe_n = wrl_n_reg;
  assign upper_byte_write_strobe_n = wrh_n_reg;
  assign read_write = rw_reg;
  assign row_strobe_n = ras_n_reg;
  assign select_zero_n = sel_pin_n[0];
  assign select_one_n = sel_pin_n[1];
  assign select_two_n = sel_pin_n[2];
  assign addr_latch = ale_reg;
  assign addr_latch_oe = ale_oe_reg;
  assign external_master_grant_n = grant_n_reg;
  // Toggles even with the pin disabled, so re-enable keeps phase
  assign clk_div_out = clkdiv_reg;
  assign clk_div_oe = clkdiv_oe_reg;
  assign pull_connect = pull_reg;
  assign port_bus_fixed = fixed_reg;

  chk_rw_write: assert property (
    (state_reg == EMBI_ST_STRB && write_reg) |=> !read_write)
    else $error("read/write not low in write cycle");

  chk_rd_level: assert property (
    !read_strobe_n |-> read_write && ctl_oe)
    else $error("read strobe without read level");

  chk_rd_width: assert property (
    $fell(read_strobe_n) |-> !read_strobe_n [*3])
    else $error("read strobe shorter than three cycles");

  chk_grant_float: assert property (
    !external_master_grant_n |-> !ctl_oe && !address_lines_oe &&
      muxed_addr_data_lines_oe == 16'h0000)
    else $error("grant given while pins driven");

  chk_grant_gap: assert property (
    (state_reg == EMBI_ST_STRB) |=> external_master_grant_n)
    else $error("grant inside a bus cycle");

  chk_release_drive: assert property (
    (state_reg == EMBI_ST_GRANT && !master_req) |-> ##2 ctl_oe)
    else $error("bus not driven after request withdrawn");

  chk_low_wr_lane: assert property (
    !lower_byte_write_strobe_n |->
      muxed_addr_data_lines_oe[7:0] == 8'hFF && !read_write)
    else $error("lower write strobe without data");

  chk_up_wr_lane: assert property (
    !upper_byte_write_strobe_n |->
      muxed_addr_data_lines_oe[15:8] == 8'hFF && lower_byte_write_strobe_n
      == !be_reg[0])
    else $error("upper write strobe without data");

  chk_ale_off: assert property (
    !ale_enable |=> !addr_latch_oe)
    else $error("address latch strobe not disabled");

  chk_clk_half: assert property (
    clk_div_out |=> !clk_div_out ##1 clk_div_out)
    else $error("clock out not system clock halved");

endmodule

/* hdl/embi_map.svh */
// Purpose: constants of the external memory bus interface
// Assumes: included by its bare name wherever a constant is needed
// Notes: counts are in cycles of the 125 MHz system clock
`ifndef EMBI_MAP_SVH
`define EMBI_MAP_SVH

`define EMBI_ADDR_W 24
`define EMBI_DATA_W 16
`define EMBI_GRP_W 8
`define EMBI_SEL_N 3
// Strobe phase length before the wait input is honoured
`define EMBI_STRB_CYC 2'h3
// Cycles of strobe before the column strobe falls
`define EMBI_CAS_DLY 2'h1
`define EMBI_CNT_W 2
`define EMBI_CLKDIV_RST 1'b1
`define EMBI_LANE_ON 8'hFF
`define EMBI_LANE_OFF 8'h00

`endif

/* hdl/embi_pkg.sv */
// Purpose: types of the external memory bus interface
// Assumes: nothing beyond the map header
// Notes: state codes are written out for easy waveform reading
package embi_pkg;

  typedef enum logic [2:0] {
    EMBI_ST_IDLE  = 3'h0,
    EMBI_ST_ADDR  = 3'h1,
    EMBI_ST_STRB  = 3'h2,
    EMBI_ST_HOLD  = 3'h3,
    EMBI_ST_GRANT = 3'h4
  } embi_state_t;

endpackage

/* hdl/embi_sel_if.sv */
// Purpose: carrier between the bus sequencer and one select decoder
// Assumes: one instance per select output
// Notes: mask bits set to one take part in the compare
`include "embi_map.svh"

interface embi_sel_if;
  logic [`EMBI_ADDR_W-1:0] addr;
  logic [`EMBI_ADDR_W-1:0] base;
  logic [`EMBI_ADDR_W-1:0] mask;
  logic enable;
  logic dram;
  logic drive;
  logic cas;
  logic hit;
  logic pin_n;

  modport dec (
    input addr,
    input base,
    input mask,
    input enable,
    input dram,
    input drive,
    input cas,
    output hit,
    output pin_n
  );

  modport ctl (
    output addr,
    output base,
    output mask,
    output enable,
    output dram,
    output drive,
    output cas,
    input hit,
    input pin_n
  );
endinterface

/* hdl/embi_sel_decode.sv */
// Purpose: one chip-select / column-strobe block
// Assumes: hit is combinational on the offered address
// Notes: the pin is registered, one cycle behind drive and cas
module embi_sel_decode
  import embi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  embi_sel_if.dec sel
);

  logic pin_n_reg;
  logic pin_n_next;
  logic hit_c;

  always_comb begin
    hit_c = sel.enable && ((sel.addr & sel.mask) == (sel.base & sel.mask));
    pin_n_next = 1'b1;
    if (sel.drive && hit_c) begin
      // Dynamic memory turns the select into a column strobe
      pin_n_next = sel.dram ? !sel.cas : 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_n_reg <= 1'b1;
    end else begin
      pin_n_reg <= pin_n_next;
    end
  end

  assign sel.hit = hit_c;
  assign sel.pin_n = pin_n_reg;

  chk_sel_low: assert property (
    @(posedge clk) disable iff (!rst_n)
    (sel.drive && hit_c && !sel.dram) |=> !sel.pin_n)
    else $error("select not low inside its area");

  chk_cas_follow: assert property (
    @(posedge clk) disable iff (!rst_n)
    (sel.dram && !(sel.drive && hit_c && sel.cas)) |=> sel.pin_n)
    else $error("column strobe low outside strobe phase");

endmodule

/* tb/embi_mem_model.sv */
// Purpose: external memory and slow peripheral on the multiplexed bus
// Assumes: test addresses keep A23..16 zero when A7..0 are on the group
// Notes: data is driven only while the read strobe is low
`include "embi_map.svh"
module embi_mem_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic ugh,
  input wire logic [`EMBI_DATA_W-1:0] ad_out,
  input wire logic [`EMBI_GRP_W-1:0] addr_grp,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_lo_n,
  input wire logic wr_hi_n,
  output logic [`EMBI_DATA_W-1:0] ad_in,
  output logic wait_n,
  output logic [`EMBI_ADDR_W-1:0] cur_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:1023];
  logic [7:0] pat = 8'h5A;
  logic [2:0] wcnt = 3'h0;
  logic [9:0] a;
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 8'(i * 7 + 3);
  end
  assign a = cur_addr[9:0];
  always @(posedge clk) begin
    pat <= pat + 8'h1D;
    if (ale) cur_addr <= ugh ? {addr_grp, ad_out} : {8'h00, ad_out};
    if (!wr_lo_n) mem[a] <= ad_out[7:0];
    if (!wr_hi_n) mem[a | 10'h1] <= ad_out[15:8];
    wcnt <= rd_n ? 3'h0 : wcnt + 3'h1;
  end
  // Released bus shows a moving pattern, never the last data
  always_comb begin
    ad_in = {pat, ~pat};
    if (!rd_n) begin
      ad_in[7:0] = mem[a];
      ad_in[15:8] = a[0] ? ~mem[a] : mem[a | 10'h1];
    end
  end
  // Slow device pulls wait from address latch on, since the pin is synced
  assign wait_n = !(slow && (ale || (!rd_n && wcnt < 3'h2)));
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench of the external memory bus interface
// Assumes: 256-byte areas at 0x000 wide, 0x100 narrow, 0x200 dynamic
// Notes: responses are matched in order against a queue of notes
`include "embi_map.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [15:0] d; bit rd; int lat; int t;} embi_exp_t;
  logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, req_dummy = 1'b0;
  logic [23:0] req_addr = 24'h0, last_addr = 24'h0;
  logic [15:0] req_wdata = 16'h0;
  logic [1:0] req_be = 2'h3;
  logic [2:0][23:0] sel_base = {24'h000200, 24'h000100, 24'h000000};
  logic [2:0][23:0] sel_mask = {3{24'hFFFF00}};
  logic [2:0] sel_enable = 3'h7, sel_dram = 3'h4, sel_bus8 = 3'h2;
  logic upper_group_high = 1'b1, ale_enable = 1'b1;
  logic clk_out_enable = 1'b1, pull_enable = 1'b1, rom_less = 1'b0;
  logic bus_width_strap = 1'b0, external_master_request_n = 1'b1;
  wire logic req_ready, rsp_valid, external_master_grant_n, wait_n;
  wire logic [15:0] rsp_rdata, muxed_addr_data_lines_in;
  wire logic [15:0] muxed_addr_data_lines_out, muxed_addr_data_lines_oe;
  wire logic [7:0] address_lines;
  wire logic [23:0] cur_addr;
  wire logic address_lines_oe, ctl_oe, read_strobe_n, read_write;
  wire logic lower_byte_write_strobe_n, upper_byte_write_strobe_n;
  wire logic row_strobe_n, select_zero_n, select_one_n, select_two_n;
  wire logic addr_latch, addr_latch_oe, clk_div_out, clk_div_oe;
  wire logic pull_connect, port_bus_fixed;
  int num_errors = 0, n_tests = 0, cyc = 0, cas_seen = 0, seed = 60;
  logic [7:0] sh [0:1023];
  embi_exp_t exp_q[$];
  embi_exp_t w_e;
  logic b;
  logic [23:0] ad;

  always #4 clk = ~clk;

  embi_bus_top i_dut (.clk, .rst_n, .req_valid, .req_write, .req_dummy,
    .req_addr, .req_wdata, .req_be, .req_ready, .rsp_valid, .rsp_rdata,
    .sel_base, .sel_mask, .sel_enable, .sel_dram, .sel_bus8,
    .upper_group_high, .ale_enable, .clk_out_enable, .pull_enable,
    .rom_less, .bus_width_strap, .wait_n, .external_master_request_n,
    .external_master_grant_n, .muxed_addr_data_lines_in,
    .muxed_addr_data_lines_out, .muxed_addr_data_lines_oe, .address_lines,
    .address_lines_oe, .ctl_oe, .read_strobe_n, .lower_byte_write_strobe_n,
    .upper_byte_write_strobe_n, .read_write, .row_strobe_n, .select_zero_n,
    .select_one_n, .select_two_n, .addr_latch, .addr_latch_oe, .clk_div_out,
    .clk_div_oe, .pull_connect, .port_bus_fixed);

  embi_mem_model i_mem (.clk, .slow, .ugh(upper_group_high),
    .ad_out(muxed_addr_data_lines_out), .addr_grp(address_lines),
    .ale(addr_latch), .rd_n(read_strobe_n),
    .wr_lo_n(lower_byte_write_strobe_n), .wr_hi_n(upper_byte_write_strobe_n),
    .ad_in(muxed_addr_data_lines_in), .wait_n, .cur_addr);

  task automatic report_and_stop;
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Ceiling far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop;
    end
  end

  task automatic access(input bit wr, dm, input logic [23:0] a,
      input logic [15:0] wd, input logic [1:0] be, input int lat);
    embi_exp_t e;
    @(negedge clk);
    req_valid = 1'b1;
    req_write = wr;
    req_dummy = dm;
    req_addr = a;
    req_wdata = wd;
    req_be = be;
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    last_addr = a;
    e.d = {sh[a[9:0] | 10'h1], sh[a[9:0]]};
    e.rd = !wr && !dm;
    e.lat = lat;
    e.t = cyc - 1;
    exp_q.push_back(e);
    if (wr && be[0]) sh[a[9:0]] = wd[7:0];
    if (wr && be[1]) sh[a[9:0] | 10'h1] = wd[15:8];
  endtask

  task automatic drain;
    for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(negedge clk);
    `CHK("drained", 0, exp_q.size())
  endtask

  always @(negedge clk) if (rsp_valid === 1'b1) begin
    w_e = exp_q.pop_front();
    if (w_e.rd) `CHK("rsp_rdata", w_e.d, rsp_rdata)
    if (w_e.lat > 0) `CHK("latency", w_e.lat, cyc - w_e.t)
    else `CHK("stretched", 1'b1, (cyc - w_e.t) > 6)
  end

  always @(negedge clk) if (rst_n) begin
    if (select_two_n === 1'b0) cas_seen++;
    if (ctl_oe === 1'b1 && read_strobe_n === 1'b0) begin
      `CHK("rw_rd", 1'b1, read_write)
      `CHK("sel0", cur_addr[23:8] != 16'h0, select_zero_n)
      `CHK("sel1", cur_addr[23:8] != 16'h1, select_one_n)
      `CHK("row", cur_addr[23:8] != 16'h2, row_strobe_n)
    end
    if (lower_byte_write_strobe_n === 1'b0)
      `CHK("rw_wr", 1'b0, read_write)
    if (addr_latch === 1'b1) begin
      `CHK("ad_oe", 16'hFFFF, muxed_addr_data_lines_oe)
      `CHK("ad_lo", last_addr[15:1], muxed_addr_data_lines_out[15:1])
      `CHK("grp", (upper_group_high ? last_addr[23:16] : last_addr[7:0])
        & 8'hFE, address_lines & 8'hFE)
    end
  end

  initial begin
    for (int i = 0; i < 1024; i++) sh[i] = 8'(i * 7 + 3);
    repeat (3) @(negedge clk);
    `CHK("clk_rst", 1'b1, clk_div_out)
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    b = clk_div_out;
    @(negedge clk);
    `CHK("clk_div", ~b, clk_div_out)
    ale_enable = 1'b0;
    clk_out_enable = 1'b0;
    pull_enable = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("ale_oe", 1'b0, addr_latch_oe)
    `CHK("clk_oe", 1'b0, clk_div_oe)
    `CHK("pull", 1'b0, pull_connect)
    ale_enable = 1'b1;
    clk_out_enable = 1'b1;
    pull_enable = 1'b1;
    access(1'b0, 1'b1, 24'h000020, 16'h0, 2'b11, 6);
    repeat (6) begin
      @(negedge clk);
      `CHK("dummy", 4'hF, {read_write, read_strobe_n,
        lower_byte_write_strobe_n, upper_byte_write_strobe_n})
    end
    for (int i = 0; i < 6; i++) begin
      ad = {14'h0, 2'(i % 3), 7'($random(seed)), 1'b0};
      if (i % 3 != 1) begin
        access(1'b1, 1'b0, ad, 16'($random(seed)), 2'b11, 6);
        access(1'b1, 1'b0, ad, 16'($random(seed)), 2'(1 + i % 2), 6);
      end
      access(1'b0, 1'b0, ad, 16'h0, 2'b11, (i % 3 == 1) ? 11 : 6);
    end
    drain;
    `CHK("cas", 1'b1, cas_seen > 0)
    access(1'b1, 1'b0, 24'hFF0040, 16'hA55A, 2'b11, 6);
    access(1'b0, 1'b0, 24'hFF0040, 16'h0, 2'b11, 6);
    drain;
    upper_group_high = 1'b0;
    access(1'b0, 1'b0, 24'h000044, 16'h0, 2'b11, 6);
    drain;
    upper_group_high = 1'b1;
    slow = 1'b1;
    access(1'b0, 1'b0, 24'h000010, 16'h0, 2'b11, 0);
    drain;
    slow = 1'b0;
    rom_less = 1'b1;
    bus_width_strap = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("fixed", 1'b1, port_bus_fixed)
    access(1'b0, 1'b0, 24'h000018, 16'h0, 2'b11, 11);
    drain;
    bus_width_strap = 1'b0;
    repeat (4) @(negedge clk);
    access(1'b0, 1'b0, 24'h000018, 16'h0, 2'b11, 6);
    drain;
    rom_less = 1'b0;
    access(1'b0, 1'b0, 24'h000030, 16'h0, 2'b11, 6);
    @(negedge clk);
    external_master_request_n = 1'b0;
    for (int i = 0; i < 30 && external_master_grant_n !== 1'b0; i++)
      @(negedge clk);
    `CHK("grant", 1'b0, external_master_grant_n)
    `CHK("grant_late", 0, exp_q.size())
    `CHK("float", 17'h0, {ctl_oe, muxed_addr_data_lines_oe})
    `CHK("a_float", 1'b0, address_lines_oe)
    `CHK("no_inner", 1'b0, req_ready)
    external_master_request_n = 1'b1;
    for (int i = 0; i < 10 && external_master_grant_n !== 1'b1; i++)
      @(negedge clk);
    repeat (3) @(negedge clk);
    `CHK("redrive", 2'b11, {ctl_oe, address_lines_oe})
    drain;
    report_and_stop;
  end
endmodule
